// [rtl/fpc_front_panel.v]
// front panel control: switches, cpu conditioning and lamps
`include "fpc_defines.vh"
// Overview of operation
// - run lets cpu go, panel ignored but stop, reset and bus clear
// - stop holds cpu waiting, panel enabled
// - step releases one machine or instruction cycle
// - slow held steps about twice per second
// - examine reads switch address, shows data
// - examine following reads next address
// - deposit writes low switches at shown address
// - deposit following writes next address
// - reset clears program counter and interrupt enable
// - bus clear switch drives system clear
// - protect blocks writes, unprotect allows them
// - accumulator display shows accumulator on data
// - accumulator load copies low switches
// - input reads port of upper switches
// - output sends accumulator to upper port
// - switch up is one, down zero
// - panel port input returns sense switches
// - status lamps mirror cpu state
// - stack lamp lights on stack address
// - address lamps show examined address
// - power on clears pc, cpu waits
module fpc_front_panel #(
    parameter DEBOUNCE_CYC = `FPC_DEBOUNCE_CYC,
    parameter SLOW_STEP_CYC = `FPC_SLOW_STEP_CYC
) (
    input wire core_clk,
    input wire resetn,
    input wire clkEn,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // panel pins
    input wire [15:0] addrSwitch,
    input wire [15:0] panelSwitch,
    // cpu conditioning
    output reg cpuReady,
    output reg cpuReset,
    output reg busClear,
    output reg memProtect,
    output reg memUnprotect,
    input wire cpuSync,
    input wire [7:0] cpuStatus,
    input wire cpuInte,
    input wire cpuWait,
    input wire cpuHoldAck,
    input wire memProtected,
    input wire [15:0] busAddr,
    input wire [7:0] busData,
    input wire [15:0] cpuStackPtr,
    // panel request channel
    output reg reqValid,
    output reg [2:0] reqKind,
    output reg [15:0] reqAddr,
    output reg [7:0] reqData,
    input wire reqDone,
    input wire [7:0] reqRdData,
    // sense switch port
    input wire ioReadStrobe,
    input wire [7:0] ioReadPort,
    output reg senseHit,
    output reg [7:0] senseData,
    // lamps
    output reg [15:0] addrLamp,
    output reg [7:0] dataLamp,
    output reg protectLamp,
    output reg irqEnabledLamp,
    output reg memReadLamp,
    output reg deviceReadLamp,
    output reg m1Lamp,
    output reg outputLamp,
    output reg haltedLamp,
    output reg writeCycleLamp,
    output reg intAckLamp,
    output reg waitLamp,
    output reg holdAcknowledgedLamp,
    output reg stackLamp
);
    // ==========================================
    // operation states
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ = 2'h1;
    localparam ST_STEP = 2'h2;
    localparam ST_INIT = 2'h3;
    // ==========================================
    // declarations
    reg [15:0] addrMeta, addrSync, swMeta, swSync, swSampleA, swLevel;
    reg [15:0] swPulse, panelAddr, next_panelAddr;
    reg [31:0] debCnt, slowCnt;
    reg debTick, slowFire, running, stepInstr, seenSync, showPanel, next_go;
    reg [1:0] state;
    reg [2:0] next_kind;
    reg [7:0] next_data;
    wire wbReq;
    wire [15:0] rose;
    // ==========================================
    // helpers
    // true when the step cycle ends on this sync
    function stepEnd;
        input instrMode;
        input m1;
        begin
            stepEnd = ~instrMode | m1;
        end
    endfunction
    // read kinds update the data lamps
    function isRead;
        input [2:0] kind;
        begin
            isRead = (kind == `FPC_REQ_MEMRD) |
                (kind == `FPC_REQ_ACCRD) |
                (kind == `FPC_REQ_IOIN);
        end
    endfunction
    // ==========================================
    // pin synchronisers
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addrMeta <= 16'h0000;
            addrSync <= 16'h0000;
            swMeta <= 16'h0000;
            swSync <= 16'h0000;
        end else if (clkEn) begin
            addrMeta <= addrSwitch; // up is one
            addrSync <= addrMeta;
            swMeta <= panelSwitch;
            swSync <= swMeta;
        end
    end
    // ==========================================
    // debounce: level taken when two spaced samples agree
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            debCnt <= 32'h0000_0000;
            debTick <= 1'b0;
        end else if (clkEn) begin
            debTick <= 1'b0;
            if (debCnt >= DEBOUNCE_CYC - 1) begin
                debCnt <= 32'h0000_0000;
                debTick <= 1'b1;
            end else begin
                debCnt <= debCnt + 32'h0000_0001;
            end
        end
    end
    assign rose = swSync & ~swLevel & swSampleA;
    // one pulse per actuation
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            swSampleA <= 16'h0000;
            swLevel <= 16'h0000;
            swPulse <= 16'h0000;
        end else if (clkEn) begin
            swPulse <= 16'h0000;
            if (debTick) begin
                swSampleA <= swSync;
                // stable across two samples
                swLevel <= (swSync & swSampleA) |
                    (swLevel & (swSync | swSampleA));
                swPulse <= rose;
            end
        end
    end
    // ==========================================
    // slow step rate generator
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slowCnt <= 32'h0000_0000;
            slowFire <= 1'b0;
        end else if (clkEn) begin
            slowFire <= 1'b0;
            if (!swLevel[`FPC_SW_SLOW] || running) begin
                slowCnt <= 32'h0000_0000;
            end else if (slowCnt >= SLOW_STEP_CYC - 1) begin
                slowCnt <= 32'h0000_0000;
                slowFire <= 1'b1;
            end else begin
                slowCnt <= slowCnt + 32'h0000_0001;
            end
        end
    end
    // ==========================================
    // pick one panel request from the pulses
    always @* begin
        next_go = 1'b1;
        next_kind = `FPC_REQ_MEMRD;
        next_data = addrSync[7:0];
        next_panelAddr = panelAddr;
        if (swPulse[`FPC_SW_EXAM]) begin
            next_panelAddr = addrSync;
        end else if (swPulse[`FPC_SW_EXNEXT]) begin
            next_panelAddr = panelAddr + 16'h0001;
        end else if (swPulse[`FPC_SW_DEP]) begin
            next_kind = `FPC_REQ_MEMWR;
        end else if (swPulse[`FPC_SW_DEPNEXT]) begin
            next_kind = `FPC_REQ_MEMWR;
            next_panelAddr = panelAddr + 16'h0001;
        end else if (swPulse[`FPC_SW_ACCDISP]) begin
            next_kind = `FPC_REQ_ACCRD;
        end else if (swPulse[`FPC_SW_ACCLOAD]) begin
            next_kind = `FPC_REQ_ACCWR;
        end else if (swPulse[`FPC_SW_INPUT]) begin
            next_kind = `FPC_REQ_IOIN;
        end else if (swPulse[`FPC_SW_OUTPUT]) begin
            next_kind = `FPC_REQ_IOOUT;
        end else begin
            next_go = 1'b0;
        end
    end
    // ==========================================
    // run, stop, step and panel request sequencer
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_INIT;
            running <= 1'b0;
            cpuReady <= 1'b0;
            cpuReset <= 1'b0;
            busClear <= 1'b0;
            memProtect <= 1'b0;
            memUnprotect <= 1'b0;
            reqValid <= 1'b0;
            reqKind <= `FPC_REQ_MEMRD;
            reqAddr <= 16'h0000;
            reqData <= 8'h00;
            panelAddr <= 16'h0000;
            showPanel <= 1'b1;
            seenSync <= 1'b0;
        end else if (clkEn) begin
            memProtect <= 1'b0;
            memUnprotect <= 1'b0;
            cpuReset <= swLevel[`FPC_SW_RESET];
            busClear <= swLevel[`FPC_SW_CLEAR];
            case (state)
                // power on: pulse reset, then wait
                ST_INIT: begin
                    cpuReset <= 1'b1;
                    cpuReady <= 1'b0;
                    panelAddr <= 16'h0000;
                    state <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (running) begin
                        cpuReady <= 1'b1;
                        showPanel <= 1'b0;
                        if (swPulse[`FPC_SW_STOP]) begin
                            running <= 1'b0;
                            cpuReady <= 1'b0;
                        end
                    end else if (swPulse[`FPC_SW_RUN]) begin
                        running <= 1'b1;
                        cpuReady <= 1'b1;
                    end else if (swPulse[`FPC_SW_STEP] ||
                            slowFire) begin
                        cpuReady <= 1'b1;
                        seenSync <= 1'b0;
                        showPanel <= 1'b0;
                        state <= ST_STEP;
                    end else if (swPulse[`FPC_SW_PROT]) begin
                        memProtect <= 1'b1;
                    end else if (swPulse[`FPC_SW_UNPROT]) begin
                        memUnprotect <= 1'b1;
                    end else if (next_go) begin
                        panelAddr <= next_panelAddr;
                        showPanel <= 1'b1;
                        reqValid <= 1'b1;
                        reqKind <= next_kind;
                        reqData <= next_data;
                        if (next_kind == `FPC_REQ_IOIN ||
                                next_kind == `FPC_REQ_IOOUT) begin
                            reqAddr <= {addrSync[15:8], addrSync[15:8]};
                        end else begin
                            reqAddr <= next_panelAddr;
                        end
                        state <= ST_REQ;
                    end
                end
                // wait for the cpu side to finish
                ST_REQ: begin
                    if (reqDone) begin
                        reqValid <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                // one cycle released, stop at chosen sync
                ST_STEP: begin
                    if (cpuSync) begin
                        seenSync <= 1'b1;
                        if (seenSync && stepEnd(stepInstr,
                                cpuStatus[`FPC_ST_M1])) begin
                            cpuReady <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // reset switch clears the panel address only while not running
            if (swLevel[`FPC_SW_RESET] && !running) begin
                panelAddr <= 16'h0000;
            end
        end
    end
    // ==========================================
    // sense switches on panel port input
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            senseHit <= 1'b0;
            senseData <= 8'h00;
        end else if (clkEn) begin
            senseHit <= ioReadStrobe &&
                (ioReadPort == `FPC_SENSE_PORT);
            senseData <= addrSync[15:8];
        end
    end
    // ==========================================
    // lamps
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addrLamp <= 16'h0000;
            dataLamp <= 8'h00;
            protectLamp <= 1'b0;
            irqEnabledLamp <= 1'b0;
            memReadLamp <= 1'b0;
            deviceReadLamp <= 1'b0;
            m1Lamp <= 1'b0;
            outputLamp <= 1'b0;
            haltedLamp <= 1'b0;
            writeCycleLamp <= 1'b0;
            intAckLamp <= 1'b0;
            waitLamp <= 1'b0;
            holdAcknowledgedLamp <= 1'b0;
            stackLamp <= 1'b0;
        end else if (clkEn) begin
            // panel address while operating panel
            addrLamp <= showPanel ? panelAddr : busAddr;
            if (state == ST_REQ && reqDone && isRead(reqKind)) begin
                dataLamp <= reqRdData;
            end else if (!showPanel) begin
                dataLamp <= busData;
            end
            protectLamp <= memProtected;
            irqEnabledLamp <= cpuInte;
            memReadLamp <= cpuStatus[`FPC_ST_MEM_READ_LAMP];
            deviceReadLamp <= cpuStatus[`FPC_ST_INP];
            m1Lamp <= cpuStatus[`FPC_ST_M1];
            outputLamp <= cpuStatus[`FPC_ST_OUT];
            haltedLamp <= cpuStatus[`FPC_ST_HALT];
            writeCycleLamp <= cpuStatus[`FPC_ST_WO];
            intAckLamp <= cpuStatus[`FPC_ST_INTA];
            waitLamp <= cpuWait;
            holdAcknowledgedLamp <= cpuHoldAck;
            stackLamp <= (busAddr == cpuStackPtr);
        end
    end
    // ==========================================
    // wishbone slave, one wait state per access
    assign wbReq = cyc_i & stb_i & ~ack_o;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            stepInstr <= 1'b0;
        end else if (clkEn) begin
            ack_o <= wbReq;
            if (wbReq) begin
                case (adr_i)
                    `FPC_REG_CTRL: begin
                        dat_o <= {31'h0000_0000, stepInstr};
                        if (we_i && sel_i[0]) begin
                            stepInstr <= dat_i[0];
                        end
                    end
                    `FPC_REG_STATUS: begin
                        dat_o <= {panelAddr, 12'h000,
                            state, running, cpuReady};
                    end
                    `FPC_REG_LAMPS: begin
                        dat_o <= {8'h00, dataLamp, addrLamp};
                    end
                    `FPC_REG_SWITCH: begin
                        dat_o <= {swLevel, addrSync};
                    end
                    default: begin
                        dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule // fpc_front_panel

// [rtl/fpc_defines.vh]
// constants for the front panel control block
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH

// clock rate and timing
`define FPC_CLK_KHZ 40000
`define FPC_DEBOUNCE_US 5000
`define FPC_DEBOUNCE_CYC (`FPC_DEBOUNCE_US * `FPC_CLK_KHZ / 1000)
`define FPC_SLOW_STEP_MS 500
`define FPC_SLOW_STEP_CYC (`FPC_SLOW_STEP_MS * `FPC_CLK_KHZ)

// momentary switch vector positions
`define FPC_SW_RUN 0
`define FPC_SW_STOP 1
`define FPC_SW_STEP 2
`define FPC_SW_SLOW 3
`define FPC_SW_EXAM 4
`define FPC_SW_EXNEXT 5
`define FPC_SW_DEP 6
`define FPC_SW_DEPNEXT 7
`define FPC_SW_RESET 8
`define FPC_SW_CLEAR 9
`define FPC_SW_PROT 10
`define FPC_SW_UNPROT 11
`define FPC_SW_ACCDISP 12
`define FPC_SW_ACCLOAD 13
`define FPC_SW_INPUT 14
`define FPC_SW_OUTPUT 15
`define FPC_SW_COUNT 16

// panel request kinds
`define FPC_REQ_MEMRD 3'h0
`define FPC_REQ_MEMWR 3'h1
`define FPC_REQ_ACCRD 3'h2
`define FPC_REQ_ACCWR 3'h3
`define FPC_REQ_IOIN 3'h4
`define FPC_REQ_IOOUT 3'h5

// cpu status word bit positions
`define FPC_ST_MEM_READ_LAMP 0
`define FPC_ST_INP 1
`define FPC_ST_M1 2
`define FPC_ST_OUT 3
`define FPC_ST_HALT 4
`define FPC_ST_WO 5
`define FPC_ST_INTA 6

// panel sense port number
`define FPC_SENSE_PORT 8'hFF

// register offsets (byte addresses)
`define FPC_REG_CTRL 4'h0
`define FPC_REG_STATUS 4'h4
`define FPC_REG_LAMPS 4'h8
`define FPC_REG_SWITCH 4'hC
`define FPC_CTRL_RESET 32'h0000_0000

`endif

// [sim/fpc_front_panel_asserts.sv]
// port assertions for the front panel control block
`include "fpc_defines.vh"
module fpc_panel_chk (
    input wire core_clk,
    input wire resetn,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire reqValid,
    input wire [2:0] reqKind,
    input wire [15:0] reqAddr,
    input wire [7:0] reqData,
    input wire reqDone,
    input wire [7:0] reqRdData,
    input wire [15:0] addrSwitch,
    input wire ioReadStrobe,
    input wire [7:0] ioReadPort,
    input wire senseHit,
    input wire [7:0] senseData,
    input wire [7:0] dataLamp,
    input wire [15:0] busAddr,
    input wire [15:0] cpuStackPtr,
    input wire stackLamp,
    input wire [7:0] cpuStatus,
    input wire cpuInte,
    input wire cpuWait,
    input wire cpuHoldAck,
    input wire memProtected,
    input wire protectLamp,
    input wire irqEnabledLamp,
    input wire memReadLamp,
    input wire deviceReadLamp,
    input wire m1Lamp,
    input wire outputLamp,
    input wire haltedLamp,
    input wire writeCycleLamp,
    input wire intAckLamp,
    input wire waitLamp,
    input wire holdAcknowledgedLamp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // ========
    // bus answer and panel requests
    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_hold;
        reqValid && !reqDone
            |=> reqValid && $stable({reqKind, reqAddr, reqData});
    endproperty
    a_hold: assert property (p_hold) else $error("req moved");
    property p_end;
        reqValid && reqDone |=> !reqValid;
    endproperty
    a_end: assert property (p_end) else $error("req stuck");
    property p_rd;
        reqValid && reqDone && reqKind inside {`FPC_REQ_MEMRD, `FPC_REQ_ACCRD}
            |=> dataLamp == $past(reqRdData);
    endproperty
    a_rd: assert property (p_rd) else $error("bad data lamp");
    property p_dep;
        reqValid && reqKind == `FPC_REQ_MEMWR |-> reqData == addrSwitch[7:0];
    endproperty
    a_dep: assert property (p_dep) else $error("bad deposit");
    property p_io;
        reqValid && reqKind inside {`FPC_REQ_IOIN, `FPC_REQ_IOOUT}
            |-> reqAddr == {2{addrSwitch[15:8]}};
    endproperty
    a_io: assert property (p_io) else $error("bad port");
    // ========
    // sense port and stack lamp
    property p_sense;
        ioReadStrobe && ioReadPort == `FPC_SENSE_PORT
            |=> senseHit && senseData == addrSwitch[15:8];
    endproperty
    a_sense: assert property (p_sense) else $error("bad sense");
    property p_stack;
        $past(resetn) |-> stackLamp == $past(busAddr == cpuStackPtr);
    endproperty
    a_stack: assert property (p_stack) else $error("bad stack");
    // status lamps follow the cpu state one cycle later
    property p_lamps;
        $past(resetn) |-> {protectLamp, irqEnabledLamp, waitLamp,
            holdAcknowledgedLamp, intAckLamp, writeCycleLamp, haltedLamp,
            outputLamp, m1Lamp, deviceReadLamp, memReadLamp}
            == $past({memProtected, cpuInte, cpuWait, cpuHoldAck,
            cpuStatus[6:0]});
    endproperty
    a_lamps: assert property (p_lamps) else $error("bad lamps");
    c_req: cover property (reqValid && reqDone);
    c_sense: cover property (senseHit);
    c_ack: cover property (ack_o);
endmodule // fpc_panel_chk

// [sim/fpc_bus_model.sv]
// memory and processor stand-in behind the panel requests
`include "fpc_defines.vh"
module fpc_bus_model (
    input wire core_clk,
    input wire resetn,
    input wire slow,
    input wire reqValid,
    input wire [2:0] reqKind,
    input wire [15:0] reqAddr,
    input wire [7:0] reqData,
    input wire memProtect,
    input wire memUnprotect,
    output logic reqDone,
    output logic [7:0] reqRdData,
    output logic memProtected
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] acc, outPort, outData;
    int cnt;
    // memory preset to a pattern of its address
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
    // answer a held request promptly or after a wait
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {reqDone, memProtected, cnt, acc} <= 0;
            reqRdData <= 8'hA5;
        end else begin
            reqDone <= 0;
            reqRdData <= ~reqRdData; // no stale byte between answers
            if (memProtect) memProtected <= 1;
            if (memUnprotect) memProtected <= 0;
            if (reqValid && !reqDone) cnt <= cnt + 1;
            if (reqValid && !reqDone && cnt >= (slow ? 6 : 0)) begin
                cnt <= 0;
                reqDone <= 1;
                case (reqKind)
                    `FPC_REQ_MEMRD: reqRdData <= mem[reqAddr];
                    `FPC_REQ_MEMWR: if (!memProtected) begin
                        mem[reqAddr] <= reqData;
                    end
                    `FPC_REQ_ACCRD: reqRdData <= acc;
                    `FPC_REQ_ACCWR: acc <= reqData;
                    `FPC_REQ_IOIN: acc <= reqAddr[7:0] ^ 8'hC3;
                    default: {outPort, outData} <= {reqAddr[7:0], acc};
                endcase
            end
        end
    end
endmodule // fpc_bus_model

// [sim/fpc_front_panel_bench.sv]
// self-checking bench for the front panel control block
module fpc_front_panel_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // signals
    logic core_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, slow = 0;
    logic cpuSync = 0, cpuInte = 0, cpuWait = 0, cpuHoldAck = 0;
    logic ioReadStrobe = 0;
    logic [3:0] adr = 0;
    logic [31:0] dat = 0, q;
    logic [15:0] addrSwitch = 0, panelSwitch = 0, a, d;
    logic [15:0] busAddr = 0, cpuStackPtr = 0;
    logic [7:0] cpuStatus = 0, busData = 0, ioReadPort = 0;
    logic [7:0] em [int];
    wire [31:0] dat_o;
    wire [15:0] reqAddr, addrLamp;
    wire [7:0] reqData, reqRdData, senseData, dataLamp;
    wire [2:0] reqKind;
    wire ack_o, cpuReady, cpuReset, busClear, memProtect, memUnprotect;
    wire memProtected, reqValid, reqDone, senseHit;
    int seed = 69, fails = 0, n_tests = 0, cycles = 0;
    int rises = 0, reqs = 0, r0, k;
    // ========
    // design and far side
    fpc_front_panel #(.DEBOUNCE_CYC(4), .SLOW_STEP_CYC(50)) dut (
        .core_clk, .resetn, .clkEn(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o, .ack_o,
        .addrSwitch, .panelSwitch, .cpuReady, .cpuReset, .busClear,
        .memProtect, .memUnprotect, .cpuSync, .cpuStatus, .cpuInte,
        .cpuWait, .cpuHoldAck, .memProtected, .busAddr, .busData,
        .cpuStackPtr, .reqValid, .reqKind, .reqAddr, .reqData, .reqDone,
        .reqRdData, .ioReadStrobe, .ioReadPort, .senseHit, .senseData,
        .addrLamp, .dataLamp, .protectLamp(), .irqEnabledLamp(),
        .memReadLamp(), .deviceReadLamp(), .m1Lamp(), .outputLamp(),
        .haltedLamp(), .writeCycleLamp(), .intAckLamp(), .waitLamp(),
        .holdAcknowledgedLamp(), .stackLamp());
    fpc_bus_model mdl (.core_clk, .resetn, .slow, .reqValid, .reqKind,
        .reqAddr, .reqData, .memProtect, .memUnprotect, .reqDone,
        .reqRdData, .memProtected);
    // 25 ns clock
    always #12.5 core_clk = ~core_clk;
    // random processor state, counts and hang limit
    always @(posedge core_clk) begin
        {cpuStatus, busData, cpuSync, cpuInte, cpuWait, cpuHoldAck}
            <= 20'($random(seed));
        busAddr <= 16'($random(seed) & 3);
        cpuStackPtr <= 16'($random(seed) & 3);
        if ($rose(cpuReady)) rises++;
        if ($rose(reqValid)) reqs++;
        if (++cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ========
    // tasks
    function automatic logic [7:0] f(input logic [15:0] x);
        return em.exists(x) ? em[x] : x[7:0] ^ 8'h5A;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic [3:0] ad, input logic w, input int wd);
        {cyc, stb, we, adr, dat} <= {2'b11, w, ad, wd};
        do @(posedge core_clk); while (ack_o !== 1);
        q = dat_o;
        {cyc, stb} <= 0;
        @(posedge core_clk);
    endtask
    task automatic press(input int b, input int hold);
        panelSwitch[b] <= 1;
        repeat (hold) @(posedge core_clk);
        panelSwitch[b] <= 0;
        repeat (30) @(posedge core_clk);
    endtask
    task automatic do_reset;
        resetn <= 0;
        repeat (8) @(posedge core_clk);
        resetn <= 1;
        repeat (3) @(posedge core_clk);
        chk("ready", cpuReady, 0);
        chk("lamp", addrLamp, 0);
    endtask
    task automatic report_and_stop;
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ========
    // scenarios
    initial begin
        do_reset();
        wb(4'h0, 1, 1);
        wb(4'h0, 0, 0);
        chk("ctrl", q, 1);
        wb(4'h2, 1, -1);
        wb(4'h2, 0, 0);
        chk("hole", q, 0);
        a = 16'($random(seed));
        addrSwitch <= a;
        r0 = reqs;
        press(4, 20);
        chk("exam", dataLamp, f(a));
        chk("addr", addrLamp, a);
        chk("once", reqs - r0 == 1, 1);
        wb(4'h8, 0, 0);
        chk("lamps", q, {8'h00, f(a), a});
        press(5, 20);
        a++;
        chk("exnext", dataLamp, f(a));
        slow <= 1;
        d = 16'($random(seed));
        addrSwitch <= d;
        press(6, 20);
        em[a] = d[7:0];
        chk("dep", mdl.mem[a], d[7:0]);
        press(7, 20);
        a++;
        em[a] = d[7:0];
        chk("depnext", mdl.mem[a], d[7:0]);
        press(10, 20);
        chk("prot", memProtected, 1);
        press(7, 20);
        a++;
        chk("blocked", mdl.mem[a], f(a));
        press(11, 20);
        chk("unprot", memProtected, 0);
        press(13, 20);
        chk("accld", mdl.acc, d[7:0]);
        press(12, 20);
        chk("accshow", dataLamp, d[7:0]);
        press(14, 20);
        chk("in", mdl.acc, d[15:8] ^ 8'hC3);
        press(15, 20);
        chk("out", {mdl.outPort, mdl.outData},
            {d[15:8], d[15:8] ^ 8'hC3});
        {ioReadPort, ioReadStrobe} <= {8'hFF, 1'b1};
        @(posedge core_clk);
        ioReadStrobe <= 0;
        @(negedge core_clk);
        chk("sense", {senseHit, senseData}, {1'b1, d[15:8]});
        @(posedge core_clk);
        for (k = 0; k < 2; k++) begin
            wb(4'h0, 1, k);
            r0 = rises;
            press(2, 20);
            repeat (60) @(posedge core_clk);
            chk("step", {rises - r0 == 1, cpuReady}, 2'b10);
        end
        r0 = rises;
        press(3, 400);
        chk("slow", rises - r0 >= 5, 1);
        press(0, 20);
        r0 = reqs;
        press(4, 20);
        chk("run", {cpuReady, reqs == r0}, 2'b11);
        wb(4'h4, 0, 0);
        chk("status", q & 32'hFFFF_0003, {a, 14'h0000, 2'b11});
        press(1, 20);
        chk("stop", cpuReady, 0);
        wb(4'hC, 0, 0);
        chk("switch", q, {16'h0000, d});
        for (k = 8; k < 10; k++) begin
            panelSwitch[k] <= 1;
            repeat (20) @(posedge core_clk);
            chk("held", k == 8 ? cpuReset : busClear, 1);
            press(k, 1);
        end
        do_reset();
        report_and_stop();
    end
endmodule // fpc_front_panel_bench
bind fpc_front_panel fpc_panel_chk u_chk (.*);
